// File: shared/acf_pkg.sv
// Purpose: Shared constants, register map and decode helpers for the result compare/filter block
// Assumes: 32-bit APB, 12-bit converter results, 21 result channels
// Notes:   Each register takes one aligned word; narrow registers sit in the low bits
package acf_pkg;
	localparam int         N_UNIT     = 4;
	localparam int         N_CHAN     = 21;
	localparam int         AW         = 8;
	localparam logic [4:0] CH_LAST    = 5'h14;
	// Comparator k at k*0x20, filter k at 0x80 + k*0x10
	localparam logic [4:0] CMP_CON    = 5'h00;
	localparam logic [4:0] CMP_ENL    = 5'h04;
	localparam logic [4:0] CMP_ENH    = 5'h08;
	localparam logic [4:0] CMP_LO     = 5'h0C;
	localparam logic [4:0] CMP_HI     = 5'h10;
	localparam logic [1:0] FLT_REGION = 2'h2;
	localparam logic [3:0] FLT_CON    = 4'h0;
	localparam logic [3:0] FLT_DAT    = 4'h4;
	// Comparator control fields
	localparam int         CC_EVENT_CHANNEL_NUMBER    = 8;
	localparam int         CC_ON      = 7;
	localparam int         CC_IE      = 6;
	localparam int         CC_STAT    = 5;
	localparam int         SEL_BELOW_LOW_SELECT   = 0;
	localparam int         SEL_ABOVE_LOW_SELECT   = 1;
	localparam int         SEL_BELOW_HIGH_SELECT   = 2;
	localparam int         SEL_ABOVE_HIGH_SELECT   = 3;
	localparam int         SEL_BETWEEN_LIMITS_SELECT   = 4;
	// Filter control fields
	localparam int         FC_ON      = 15;
	localparam int         FC_MODE    = 13;
	localparam int         FC_RATIO   = 10;
	localparam int         FC_IE      = 9;
	localparam int         FC_RDY     = 8;
	localparam logic [1:0] MODE_OS    = 2'h0;
	localparam logic [1:0] MODE_AV    = 2'h3;
	localparam logic [3:0] RES_INT    = 4'hC;

	typedef enum {RK_NONE, RK_CCON, RK_CENL, RK_CENH, RK_CLO, RK_CHI,
		RK_FCON, RK_FDAT} acf_reg_t;

	function automatic acf_reg_t acf_decode(input logic [AW-1:0] a);
		acf_reg_t k;
		k = RK_NONE;
		if (a[1:0] != 2'h0) begin
			k = RK_NONE;
		end else if (!a[7]) begin
			case (a[4:0])
				CMP_CON: k = RK_CCON;
				CMP_ENL: k = RK_CENL;
				CMP_ENH: k = RK_CENH;
				CMP_LO:  k = RK_CLO;
				CMP_HI:  k = RK_CHI;
				default: k = RK_NONE;
			endcase
		end else if (a[7:6] == FLT_REGION) begin
			case (a[3:0])
				FLT_CON: k = RK_FCON;
				FLT_DAT: k = RK_FDAT;
				default: k = RK_NONE;
			endcase
		end
		return k;
	endfunction : acf_decode

	function automatic logic [1:0] acf_unit(input logic [AW-1:0] a);
		return a[7] ? a[5:4] : a[6:5];
	endfunction : acf_unit

	// Number of samples per result, as a power of two
	function automatic logic [3:0] acf_log2n(input logic [1:0] m, input logic [2:0] r);
		if (m == MODE_AV)
			return {1'b0, r} + 4'h1;
		else if (r[2])
			return {1'b0, r[1:0], 1'b1};
		else
			return {1'b0, r[1:0], 1'b0} + 4'h2;
	endfunction : acf_log2n

	// Result width in bits: 12 when averaging, 12 plus fraction bits when oversampling
	function automatic logic [4:0] acf_width(input logic [1:0] m, input logic [2:0] r);
		if (m == MODE_AV)
			return {1'b0, RES_INT};
		else
			return {1'b0, RES_INT} + {3'h0, r[1:0]} + 5'h01;
	endfunction : acf_width

	function automatic logic [3:0] acf_shift(input logic [1:0] m, input logic [2:0] r);
		return acf_log2n(m, r) + RES_INT - 4'(acf_width(m, r));
	endfunction : acf_shift
endpackage : acf_pkg

// File: shared/acf_res_if.sv
// Purpose: Carries one converter result (channel and value) from the top to the filters
// Assumes: valid is a one-cycle pulse per result buffer update
// Notes:   src drives, snk only listens
`timescale 1ns/1ps
interface acf_res_if;
	logic        valid;
	logic [4:0]  chan;
	logic [11:0] data;
	modport src (output valid, output chan, output data);
	modport snk (input valid, input chan, input data);
endinterface : acf_res_if

// File: design/acf_filter.sv
// Purpose: One oversampling/averaging filter on a selected result channel
// Assumes: At most one result per clock on the shared result carrier
// Notes:   A result caught during a data read still sets the ready flag
`timescale 1ns/1ps
module acf_filter (
	input  wire logic        clk,
	input  wire logic        rst_n,
	acf_res_if.snk           rin,
	input  wire logic        on,
	input  wire logic [1:0]  mode,
	input  wire logic [2:0]  ratio,
	input  wire logic [4:0]  chsel,
	input  wire logic        rd_clr,
	output logic      [15:0] result,
	output logic             rdy
);
	import acf_pkg::*;

	logic [19:0] acc;
	logic [19:0] sum;
	logic [8:0]  cnt;
	logic        mode_ok;
	logic        take;
	logic        last;

	// Reserved modes and channel codes simply never accumulate
	assign mode_ok = (mode == MODE_OS) || (mode == MODE_AV); // RULE_05
	assign take    = on && mode_ok && rin.valid && rin.chan == chsel
		&& chsel <= CH_LAST; // RULE_10 RULE_13
	assign sum     = acc + {8'h00, rin.data};
	// >= so that a ratio lowered mid-run still finishes
	assign last    = take && cnt >= (9'h001 << acf_log2n(mode, ratio)) - 9'h001;

	always_ff @(posedge clk) begin
		if (!rst_n || !on) begin
			acc <= 20'h00000;
			cnt <= 9'h000;
		end else if (last) begin
			acc <= 20'h00000;
			cnt <= 9'h000;
		end else if (take) begin
			acc <= sum;
			cnt <= cnt + 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			result <= 16'h0000;
		else if (last)
			result <= 16'(sum >> acf_shift(mode, ratio)); // RULE_06 RULE_07 RULE_08
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !on)
			rdy <= 1'b0; // RULE_04
		else if (last)
			rdy <= 1'b1; // RULE_12
		else if (rd_clr)
			rdy <= 1'b0; // RULE_12
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_off_clears_rdy: assert property (!on |=> !rdy) // RULE_04
		else $error("filter off but ready flag set");
	a_mode_legal: assert property ($rose(rdy) |-> $past(mode) == MODE_OS // RULE_05
		|| $past(mode) == MODE_AV)
		else $error("result stored in reserved mode");
	a_result_width: assert property ($rose(rdy) |-> // RULE_06 RULE_07 RULE_08
		(result >> acf_width($past(mode), $past(ratio))) == 16'h0000)
		else $error("filter result wider than its format");
	a_chsel_reserved: assert property (chsel > CH_LAST && !rdy |=> !rdy) // RULE_10
		else $error("reserved channel code produced a result");
	a_read_clears: assert property (rd_clr && !last && on |=> !rdy) // RULE_12
		else $error("ready flag survived a data read");
	a_src_channel: assert property ($rose(rdy) |-> // RULE_13
		$past(rin.valid && rin.chan == chsel))
		else $error("result stored without a matching channel result");
endmodule : acf_filter

// File: design/acf_compare_filter.sv
// Purpose: Four digital comparators and four result filters behind an APB slave
// Assumes: One converter result per clock at most, presented as a one-cycle strobe
// Notes:   APB answers with exactly one wait-free access cycle; unmapped addresses give pslverr
// What this block does
// RULE_01: On a comparator event store the five-bit channel index in the channel field.
// RULE_02: A comparator only looks at channels whose mask bit is set.
// RULE_03: Upper bits of the high mask half are unimplemented and read zero.
// RULE_04: Filter off stops it and clears ready; on lets it accumulate.
// RULE_05: Mode 00 is oversampling, 11 averaging; 01 and 10 reserved.
// RULE_06: Oversampling codes 111..100 give 128x, 32x, 8x, 2x with 4..1 fraction bits.
// RULE_07: Oversampling codes 011..000 give 256x, 64x, 16x, 4x with 4..1 fraction bits.
// RULE_08: Averaging gives 12-bit results; codes 000..111 give 2x up to 256x.
// RULE_09: With filter interrupt allowed, a ready result raises the shared interrupt.
// RULE_10: Filter channel codes 0..20 are valid; 21 and above are reserved.
// RULE_11: Any enabled limit condition on a monitored result flags a comparator event.
// RULE_12: Ready sets when a result is stored and clears when the data is read.
// RULE_13: Results arrive from per-channel buffers with their own ready strobe.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module acf_compare_filter (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [acf_pkg::AW-1:0]   paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     res_valid,
	input  wire logic [4:0]               res_chan,
	input  wire logic [11:0]              res_data,
	output logic                          irq
);
	import acf_pkg::*;

	acf_res_if rin();

	// Comparator state
	logic [N_UNIT-1:0] cmp_on;
	logic [N_UNIT-1:0] cmp_ie;
	logic [N_UNIT-1:0] cmp_stat;
	logic [4:0]        cmp_event_channel_number [N_UNIT];
	logic [4:0]        cmp_sel  [N_UNIT];
	logic [20:0]       cmp_mask [N_UNIT];
	logic [15:0]       cmp_lo   [N_UNIT];
	logic [15:0]       cmp_hi   [N_UNIT];
	logic [N_UNIT-1:0] cmp_hit;
	logic [N_UNIT-1:0] cmp_evt;
	logic [N_UNIT-1:0] clr_stat;

	// Filter state
	logic [N_UNIT-1:0] flt_on;
	logic [N_UNIT-1:0] flt_ie;
	logic [1:0]        flt_mode  [N_UNIT];
	logic [2:0]        flt_ratio [N_UNIT];
	logic [4:0]        flt_chsel [N_UNIT];
	logic [15:0]       flt_res   [N_UNIT];
	logic [N_UNIT-1:0] flt_rdy;
	logic [N_UNIT-1:0] clr_rdy;

	// Bus side
	acf_reg_t          s_kind;
	logic [1:0]        s_unit;
	logic              setup;
	logic              acc_wr;
	logic              acc_rd;
	logic [31:0]       next_rdata;

	assign rin.valid = res_valid;
	assign rin.chan  = res_chan;
	assign rin.data  = res_data;

	assign s_kind = acf_decode(paddr);
	assign s_unit = acf_unit(paddr);
	assign setup  = psel && !penable;
	assign acc_wr = psel && penable && pready && pwrite;
	assign acc_rd = psel && penable && pready && !pwrite;

	function automatic logic wsel(input acf_reg_t kd, input int k);
		return acc_wr && s_kind == kd && s_unit == 2'(k);
	endfunction : wsel

	function automatic logic cmp_match(
		input logic [4:0]  sel,
		input logic [15:0] lo,
		input logic [15:0] hi,
		input logic [15:0] v
	);
		logic lt_lo;
		logic lt_hi;
		lt_lo = v < lo;
		lt_hi = v < hi;
		return (sel[SEL_BELOW_LOW_SELECT] && lt_lo)
			|| (sel[SEL_ABOVE_LOW_SELECT] && !lt_lo)
			|| (sel[SEL_BELOW_HIGH_SELECT] && lt_hi)
			|| (sel[SEL_ABOVE_HIGH_SELECT] && !lt_hi)
			|| (sel[SEL_BETWEEN_LIMITS_SELECT] && !lt_lo && lt_hi);
	endfunction : cmp_match

	// Shift rather than index so that channel codes above 20 read as a clear mask bit
	always_comb begin
		for (int k = 0; k < N_UNIT; k++) begin
			cmp_hit[k] = res_valid && res_chan <= CH_LAST
				&& ((32'(cmp_mask[k]) >> res_chan) & 32'h1) != 32'h0; // RULE_02
			cmp_evt[k] = cmp_on[k] && cmp_hit[k]
				&& cmp_match(cmp_sel[k], cmp_lo[k], cmp_hi[k], 16'(res_data)); // RULE_11
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmp_on <= '0;
			cmp_ie <= '0;
			for (int k = 0; k < N_UNIT; k++)
				cmp_sel[k] <= 5'h00;
		end else begin
			for (int k = 0; k < N_UNIT; k++) begin
				if (wsel(RK_CCON, k)) begin
					cmp_on[k]  <= pwdata[CC_ON];
					cmp_ie[k]  <= pwdata[CC_IE];
					cmp_sel[k] <= pwdata[SEL_BETWEEN_LIMITS_SELECT:SEL_BELOW_LOW_SELECT];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < N_UNIT; k++)
				cmp_mask[k] <= 21'h000000;
		end else begin
			for (int k = 0; k < N_UNIT; k++) begin
				if (wsel(RK_CENL, k))
					cmp_mask[k][15:0] <= pwdata[15:0];
				if (wsel(RK_CENH, k))
					cmp_mask[k][20:16] <= pwdata[4:0]; // RULE_03
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < N_UNIT; k++) begin
				cmp_lo[k] <= 16'h0000;
				cmp_hi[k] <= 16'h0000;
			end
		end else begin
			for (int k = 0; k < N_UNIT; k++) begin
				if (wsel(RK_CLO, k))
					cmp_lo[k] <= pwdata[15:0];
				if (wsel(RK_CHI, k))
					cmp_hi[k] <= pwdata[15:0];
			end
		end
	end

	// A new event beats the clear from a read; switching off clears the status regardless
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmp_stat <= '0;
			for (int k = 0; k < N_UNIT; k++)
				cmp_event_channel_number[k] <= 5'h00;
		end else begin
			for (int k = 0; k < N_UNIT; k++) begin
				if (cmp_evt[k]) begin
					cmp_stat[k] <= 1'b1;
					cmp_event_channel_number[k] <= res_chan; // RULE_01
				end else if (!cmp_on[k] || (acc_rd && clr_stat[k])) begin
					cmp_stat[k] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flt_on <= '0;
			flt_ie <= '0;
			for (int k = 0; k < N_UNIT; k++) begin
				flt_mode[k]  <= MODE_OS;
				flt_ratio[k] <= 3'h0;
				flt_chsel[k] <= 5'h00;
			end
		end else begin
			for (int k = 0; k < N_UNIT; k++) begin
				if (wsel(RK_FCON, k)) begin
					flt_on[k]    <= pwdata[FC_ON]; // RULE_04
					flt_mode[k]  <= pwdata[FC_MODE+1:FC_MODE];
					flt_ratio[k] <= pwdata[FC_RATIO+2:FC_RATIO];
					flt_ie[k]    <= pwdata[FC_IE];
					flt_chsel[k] <= pwdata[4:0];
				end
			end
		end
	end

	for (genvar k = 0; k < N_UNIT; k++) begin : g_flt
		acf_filter u_flt (
			.clk    (clk),
			.rst_n  (rst_n),
			.rin    (rin),
			.on     (flt_on[k]),
			.mode   (flt_mode[k]),
			.ratio  (flt_ratio[k]),
			.chsel  (flt_chsel[k]),
			.rd_clr (acc_rd && clr_rdy[k]),
			.result (flt_res[k]),
			.rdy    (flt_rdy[k])
		);
	end

	always_comb begin
		next_rdata = 32'h00000000;
		unique case (s_kind)
			RK_CCON: next_rdata = 32'({cmp_event_channel_number[s_unit], cmp_on[s_unit], cmp_ie[s_unit],
				cmp_stat[s_unit], cmp_sel[s_unit]});
			RK_CENL: next_rdata = 32'(cmp_mask[s_unit][15:0]);
			RK_CENH: next_rdata = 32'(cmp_mask[s_unit][20:16]); // RULE_03
			RK_CLO:  next_rdata = 32'(cmp_lo[s_unit]);
			RK_CHI:  next_rdata = 32'(cmp_hi[s_unit]);
			RK_FCON: next_rdata = 32'({flt_on[s_unit], flt_mode[s_unit], flt_ratio[s_unit],
				flt_ie[s_unit], flt_rdy[s_unit], 3'h0, flt_chsel[s_unit]});
			RK_FDAT: next_rdata = 32'(flt_res[s_unit]);
			default: next_rdata = 32'h00000000;
		endcase
	end

	// Data is captured in the setup cycle so every bus output comes from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && s_kind == RK_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			prdata <= 32'h00000000;
		else if (setup && !pwrite)
			prdata <= next_rdata;
	end

	// Only flags that were actually seen by the read are cleared by it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clr_stat <= '0;
			clr_rdy  <= '0;
		end else begin
			for (int k = 0; k < N_UNIT; k++) begin
				clr_stat[k] <= setup && !pwrite && s_kind == RK_CCON
					&& s_unit == 2'(k) && cmp_stat[k];
				clr_rdy[k]  <= setup && !pwrite && s_kind == RK_FDAT
					&& s_unit == 2'(k) && flt_rdy[k]; // RULE_12
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(cmp_stat & cmp_ie) || |(flt_rdy & flt_ie); // RULE_09
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_read_con0;
		setup && !pwrite && s_kind == RK_CCON && s_unit == 2'h0 && !cmp_evt[0]
			##1 acc_rd && !cmp_evt[0];
	endsequence

	a_event_event_channel_number: assert property (cmp_evt[0] |=> cmp_stat[0] // RULE_01
		&& cmp_event_channel_number[0] == $past(res_chan))
		else $error("comparator event did not record its channel");
	a_mask_gate: assert property ($rose(cmp_stat[0]) |-> // RULE_02
		$past(res_valid && cmp_hit[0]))
		else $error("comparator flagged an unmasked channel");
	a_enh_zero: assert property (pready && !pwrite && s_kind == RK_CENH |-> // RULE_03
		prdata[31:5] == 27'h0000000)
		else $error("unimplemented mask bits read nonzero");
	a_irq_filter: assert property (flt_rdy[0] && flt_ie[0] |=> irq) // RULE_09
		else $error("ready filter with interrupt allowed left irq low");
	a_cond_below_low_select: assert property (res_valid && cmp_on[0] && cmp_hit[0] // RULE_11
		&& cmp_sel[0][SEL_BELOW_LOW_SELECT] && 16'(res_data) < cmp_lo[0] |=> cmp_stat[0])
		else $error("below-low result did not flag an event");
	a_stat_read: assert property (s_read_con0 |=> !cmp_stat[0]) // RULE_11
		else $error("comparator status not cleared by its read");
endmodule : acf_compare_filter

// File: verif/acf_res_src.sv
// Purpose: Behavioural converter cores handing results to the compare/filter block
// Assumes: At most one send per clock; caller decides spacing
// Notes:   Each idle() cycle drops valid and flips chan/data once so nothing stale can be reused
`timescale 1ns/1ps
module acf_res_src (
	input  wire logic        clk,
	output logic             res_valid,
	output logic      [4:0]  res_chan,
	output logic      [11:0] res_data
);
	initial begin
		res_valid = 1'b0;
		res_chan  = 5'h1F;
		res_data  = 12'hFFF;
	end

	task automatic send(input logic [4:0] ch, input logic [11:0] d);
		@(posedge clk);
		res_valid <= 1'b1;
		res_chan  <= ch;
		res_data  <= d;
	endtask : send

	task automatic idle();
		@(posedge clk);
		res_valid <= 1'b0;
		res_chan  <= ~res_chan;
		res_data  <= ~res_data;
	endtask : idle
endmodule : acf_res_src

// File: verif/adc_result_compare_and_filter_tb.sv
// Purpose: Self-checking bench for the result compare/filter block
// Assumes: APB slave answers in its own time; results come from acf_res_src
// Notes:   Filter expectations are summed here from the ratio table, not from the design
`timescale 1ns/1ps
module adc_result_compare_and_filter_tb;
	import acf_pkg::*;
	logic          clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, res_valid, err;
	logic [AW-1:0] paddr;
	logic [31:0]   pwdata, prdata, rd, con;
	logic [4:0]    res_chan;
	logic [11:0]   res_data;
	int            bad_count, total_checks, k, s, c, lo, hi, v, m, r, ie, n, sum, rdy, ev;

	acf_compare_filter i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .res_valid(res_valid), .res_chan(res_chan), .res_data(res_data),
		.irq(irq));
	acf_res_src i_src (.clk(clk), .res_valid(res_valid), .res_chan(res_chan),
		.res_data(res_data));

	always #5 clk = ~clk;

	function automatic logic [7:0] ca(input int u, input logic [4:0] o);
		return {1'b0, u[1:0], o};
	endfunction : ca
	function automatic logic [7:0] fa(input int u, input logic [3:0] o);
		return {FLT_REGION, u[1:0], o};
	endfunction : fa
	function automatic int f_log2n(input int md, input int rt);
		if (md == 3) return rt + 1;
		return (rt >= 4) ? 2 * (rt % 4) + 1 : 2 * (rt % 4) + 2;
	endfunction : f_log2n
	function automatic int f_shift(input int md, input int rt);
		return f_log2n(md, rt) - ((md == 3) ? 0 : rt % 4 + 1);
	endfunction : f_shift

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int w;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge clk);
			w++;
		end while (pready !== 1'b1 && w < 20);
		if (w >= 20) chk(32'h0, 32'h1, "no pready");
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
		input string msg);
		apb(1'b0, a, 32'h0);
		chk(rd & mk, e & mk, msg);
	endtask : rdchk

	task automatic irqchk(input int e, input string msg);
		repeat (2) @(posedge clk);
		#1;
		chk(32'(irq), 32'(e), msg);
	endtask : irqchk

	task automatic wrap_up();
		$display("Checks: %0d, mismatches: %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	initial begin
		// Whole run needs well under ten thousand cycles
		#300_000;
		bad_count++;
		wrap_up();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		void'($urandom(32'h9F381BA9));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int u = 0; u < 4; u++) begin
			for (int o = 0; o <= 16; o += 4) rdchk(ca(u, 5'(o)), 0, '1, "cmp reset");
			rdchk(fa(u, FLT_CON), 0, '1, "flt con reset");
			rdchk(fa(u, FLT_DAT), 0, '1, "flt data reset");
		end
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		chk(32'(err), 32'h1, "unmapped write");
		apb(1'b0, 8'hC0, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped read");
		apb(1'b1, ca(1, CMP_ENH), 32'hFFFFFFFF);
		rdchk(ca(1, CMP_ENH), 32'h1F, '1, "mask high width");
		apb(1'b1, ca(1, CMP_ENL), 32'hFFFFFFFF);
		rdchk(ca(1, CMP_ENL), 32'hFFFF, '1, "mask low width");
		// Comparators: every condition select, value exactly on a limit two times in three
		for (int i = 0; i < 20; i++) begin
			k = i % 4;
			s = i % 5;
			c = $urandom_range(20);
			lo = $urandom_range(12'h7FF, 12'h100);
			hi = $urandom_range(12'hEFF, 12'h800);
			v = (i % 3 == 0) ? $urandom_range(12'hFFF) : ((i % 3 == 1) ? lo : hi);
			apb(1'b1, ca(k, CMP_LO), lo);
			apb(1'b1, ca(k, CMP_HI), hi);
			apb(1'b1, ca(k, CMP_ENL), (c < 16) ? (1 << c) : 0);
			apb(1'b1, ca(k, CMP_ENH), (c >= 16) ? (1 << (c - 16)) : 0);
			con = (1 << CC_ON) | (1 << CC_IE) | (1 << s);
			apb(1'b1, ca(k, CMP_CON), con);
			i_src.send(5'((c + 1) % 21), 12'(v));
			i_src.idle();
			rdchk(ca(k, CMP_CON), con, 32'hFF, "masked channel");
			ev = (s == SEL_BELOW_LOW_SELECT && v < lo) || (s == SEL_ABOVE_LOW_SELECT && v >= lo) || (s == SEL_BELOW_HIGH_SELECT && v < hi)
				|| (s == SEL_ABOVE_HIGH_SELECT && v >= hi) || (s == SEL_BETWEEN_LIMITS_SELECT && v >= lo && v < hi);
			i_src.send(5'(c), 12'(v));
			i_src.idle();
			irqchk(ev, "cmp irq");
			rdchk(ca(k, CMP_CON), con | (ev << CC_STAT) | (c << CC_EVENT_CHANNEL_NUMBER),
				ev ? 32'h1FFF : 32'hFF, "cmp event");
			rdchk(ca(k, CMP_CON), con, 32'hFF, "status cleared");
			apb(1'b1, ca(k, CMP_CON), 32'h0);
		end
		// Filters: both modes, every ratio, then a reserved mode and a reserved channel
		for (int i = 0; i < 18; i++) begin
			k = i % 4;
			r = i % 8;
			m = (i < 8 || i == 17) ? 0 : ((i == 16) ? 1 : 3);
			ie = i % 2;
			c = (i == 17) ? 21 : $urandom_range(20);
			n = 1 << f_log2n(m, r);
			sum = 0;
			rdy = (i < 16);
			con = (1 << FC_ON) | (m << FC_MODE) | (r << FC_RATIO) | (ie << FC_IE) | c;
			apb(1'b1, fa(k, FLT_CON), con);
			for (int j = 0; j < n; j++) begin
				if ($urandom_range(7) == 0) i_src.send(5'((c + 3) % 21), 12'($urandom_range(4095)));
				v = $urandom_range(12'hFFF);
				sum += v;
				i_src.send(5'(c), 12'(v));
				if (j == n - 2) begin
					i_src.idle();
					rdchk(fa(k, FLT_CON), con, '1, "ready early");
				end else if ($urandom_range(7) == 0) begin
					i_src.idle();
				end
			end
			i_src.idle();
			irqchk(rdy & ie, "filter irq");
			rdchk(fa(k, FLT_CON), con | (rdy << FC_RDY), '1, "filter ready");
			if (i == 5) begin
				apb(1'b1, fa(k, FLT_CON), con & ~(32'h1 << FC_ON));
				rdchk(fa(k, FLT_CON), con & ~(32'h1 << FC_ON), '1, "off clears ready");
			end else if (rdy) begin
				rdchk(fa(k, FLT_DAT), sum >> f_shift(m, r), '1, "filter data");
				rdchk(fa(k, FLT_CON), con, '1, "ready after read");
			end
			apb(1'b1, fa(k, FLT_CON), 32'h0);
			irqchk(0, "irq released");
		end
		wrap_up();
	end
endmodule : adc_result_compare_and_filter_tb
